// file: design/dfcd_defs.svh
// Constants for the detector front-end command decoder.
// Operation
// R1: Field bit 0 is the leftmost opcode bit, unlike serial line order.
// R2: Power command sets pair power from bits 6 and 7, default off, echoes.
// R3: Unpowered pair has error and latchup masked and resets asserted.
// R4: Drive command drives pair outputs only when powered; undriven pairs are masked.
// R5: Output-type command selects digital or analogue output per pair, default digital.
// R6: Enable command puts pair in reset or operation; inputs unmasked only if enabled.
// R7: Configure command sends three bytes out, returns four status bytes plus echo.
// R8: Host powers, drives and enables the front end before configuring it.
// R9: Status command returns unmasked error and latchup bits, then echo.
// R10: Mode command picks bins per pair; argument gives active and read pages.
// R11: Init command loads 256 counters with zero or a front-end/page/address pattern.
// R12: Small read returns and clears 32 counters, high to low, three bytes each.
// R13: Full read returns and clears 256 counters, 255 down to 0, then echo.
// R14: Alarm set stores coarse and fine alarm time and clears the timer.
// R15: Timer read returns coarse two bytes, fine one byte, then echo.
// R16: Timestamp read returns stamp A, stamp B, then echo.
// R17: Any unrecognised command byte is answered with 00000011.
// R18: A late argument byte is answered with 00001111; host then resets device.
// R19: Calibration setup takes generator address and four target enables.
// R20: Calibration answer after programming; latchup disables calibration targets.
// R21: Latchup command sets prescaler divide 16 to 256 and threshold 0 to 255.
// R22: Latchup counts only if input stays asserted for the threshold time.
// R23: Each latchup input has its own counter on the shared prescaler tick.
// R24: Argument time-out is a cycle parameter; decoder then returns to idle.
`ifndef DFCD_DEFS_SVH
`define DFCD_DEFS_SVH
`define DFCD_OP_PWR 6'h20
`define DFCD_OP_DRV 6'h21
`define DFCD_OP_EN 6'h22
`define DFCD_OP_TYPE 6'h23
`define DFCD_OP_CFG 6'h24
`define DFCD_OP_MODE 6'h28
`define DFCD_OP_INIT 5'h15
`define DFCD_OP_RD32 6'h2c
`define DFCD_OP_RD256 6'h2d
`define DFCD_OP_STAT 8'h94
`define DFCD_OP_ALARM 8'hd0
`define DFCD_OP_TREAD 8'hd4
`define DFCD_OP_STAMP 8'hd8
`define DFCD_OP_CAL 8'he0
`define DFCD_OP_LATCH 4'hf
`define DFCD_REPLY_UNK 8'h03
`define DFCD_REPLY_TO 8'h0f
`define DFCD_CLK_MHZ 125
`define DFCD_ARG_TIMEOUT_US 1000
`define DFCD_PRESC_BASE 16
`define DFCD_LAST_SMALL 8'h1f
`define DFCD_LAST_FULL 8'hff
`endif

// file: design/dfcd_pkg.sv
// Types shared by the command decoder files.
package dfcd_pkg;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ARG = 8'h02,
    ST_EXEC = 8'h04,
    ST_CFG = 8'h08,
    ST_INIT = 8'h10,
    ST_CRD = 8'h20,
    ST_CLR = 8'h40,
    ST_SEND = 8'h80
  } dfcd_state_t;
endpackage : dfcd_pkg

// file: design/dfcd_counter_ram.sv
// Counter store: one port; write and registered read share one address.
`timescale 1ns/1ps
module dfcd_counter_ram #(
  parameter int DW = 24,
  parameter int AW = 12
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wData,
  output logic [DW-1:0] rData
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Read data is registered so the array maps to block memory.
  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[addr] <= wData;
    end
    rData <= mem[addr];
  end
endmodule : dfcd_counter_ram

// file: design/dfcd_command_decoder.sv
// Command decoder and response generator for four detector front ends.
`timescale 1ns/1ps
`include "dfcd_defs.svh"
module dfcd_command_decoder import dfcd_pkg::*; #(
  parameter int ArgTimeoutCyc = `DFCD_ARG_TIMEOUT_US * `DFCD_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  output logic [7:0] txData_r,
  output logic txValid_r,
  input wire logic txReady,
  input wire logic [3:0] feCfgErrIn,
  input wire logic [1:0] feLatchAnaIn,
  input wire logic [1:0] feLatchDigIn,
  output logic [1:0] fePower_r,
  output logic [1:0] feDriveOut_r,
  output logic [1:0] feAnalogue_r,
  output logic [1:0] feResetOut_r,
  output logic [3:0] feErrFlag_r,
  output logic [3:0] latchDet_r,
  output logic feCfgStart_r,
  output logic [1:0] feCfgSel_r,
  output logic [23:0] feCfgData_r,
  input wire logic feCfgDone,
  input wire logic [31:0] feCfgStatus,
  output logic [1:0] binsSmall_r,
  output logic [3:0] activePage_r,
  output logic [15:0] alarmCoarse_r,
  output logic [7:0] alarmFine_r,
  output logic timerClear_r,
  input wire logic [15:0] timerCoarse,
  input wire logic [7:0] timerFine,
  input wire logic [23:0] stampA,
  input wire logic [23:0] stampB,
  output logic [1:0] calGenSel_r,
  output logic [3:0] calTargets_r
);
  dfcd_state_t state_r;
  logic [1:0] drvEn_r;
  logic [1:0] feEnable_r;
  logic [3:0] readPage_r;
  logic [3:0] prescCode_r;
  logic [7:0] latchThr_r;
  logic [7:0] cmd_r;
  logic [23:0] arg_r;
  logic [1:0] argLeft_r;
  logic [31:0] toCnt_r;
  logic [55:0] txBuf_r;
  logic [2:0] txLeft_r;
  logic stream_r;
  logic [7:0] idx_r;
  logic memWe_r;
  logic [11:0] memAddr_r;
  logic [23:0] memWData_r;
  logic [23:0] memRData;
  logic [11:0] sync1_r;
  logic [11:0] sync2_r;
  logic [11:0] sync3_r;
  logic [11:0] pinIn_r;
  logic [7:0] prescCnt_r;
  logic prescTick_r;
  logic [7:0] latchCnt_r [0:3];
  logic [1:0] unmask;
  logic [3:0] latchRaw;
  logic [1:0] fe;

  // Field bit n counts from the left, so it is byte bit 7-n.
  function automatic logic fieldBit(input logic [7:0] b, input int n);
    fieldBit = b[3'(7 - n)]; // see R1
  endfunction : fieldBit

  // Pair vector from bits 6 and 7: index 0 is pair 0/1, index 1 is pair 2/3.
  function automatic logic [1:0] pairBits(input logic [7:0] b);
    pairBits = {fieldBit(b, 7), fieldBit(b, 6)}; // see R1
  endfunction : pairBits

  // A pair raises feErrFlag_r and latchDet_r bits only when powered, driven and enabled.
  assign unmask = fePower_r & drvEn_r & feEnable_r; // see R3 see R4 see R6
  assign latchRaw = {pinIn_r[7], pinIn_r[5], pinIn_r[6], pinIn_r[4]};
  assign fe = {fieldBit(cmd_r, 6), fieldBit(cmd_r, 7)};

  // Pins pass three flops; a change counts once the second and third agree.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 12'h000;
      sync2_r <= 12'h000;
      sync3_r <= 12'h000;
      pinIn_r <= 12'h000;
    end else begin
      sync1_r <= {feLatchDigIn, feLatchAnaIn, feCfgErrIn, 4'h0};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      if (sync2_r == sync3_r) begin
        pinIn_r <= {4'h0, sync3_r[11:4]};
      end
    end
  end

  // Front-end control outputs, re-registered so each leaves a flop.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      feDriveOut_r <= 2'h0;
      feResetOut_r <= 2'h3;
      feErrFlag_r <= 4'h0;
    end else begin
      feDriveOut_r <= fePower_r & drvEn_r; // see R4
      feResetOut_r <= ~(fePower_r & feEnable_r); // see R3 see R6
      feErrFlag_r <= pinIn_r[3:0] & {unmask[1], unmask[1], unmask[0], unmask[0]}; // see R3
    end
  end

  // Shared prescaler: one tick every 16 * (code + 1) cycles.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescCnt_r <= 8'h00;
      prescTick_r <= 1'b0;
    end else begin
      prescTick_r <= 1'b0;
      if (prescCnt_r == {prescCode_r, 4'hf}) begin // see R21
        prescCnt_r <= 8'h00;
        prescTick_r <= 1'b1;
      end else begin
        prescCnt_r <= prescCnt_r + 8'h01;
      end
    end
  end

  // One detector per input; the count restarts whenever the input drops.
  // The tick phase is not reset on assertion, hence up to one period of jitter.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gLatch
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          latchCnt_r[gi] <= 8'h00;
          latchDet_r[gi] <= 1'b0;
        end else if (!(latchRaw[gi] && unmask[gi/2])) begin
          latchCnt_r[gi] <= 8'h00; // see R22
          latchDet_r[gi] <= 1'b0;
        end else begin
          if (prescTick_r && latchCnt_r[gi] != 8'hff) begin
            latchCnt_r[gi] <= latchCnt_r[gi] + 8'h01; // see R23
          end
          latchDet_r[gi] <= (latchCnt_r[gi] >= latchThr_r); // see R22 see R23
        end
      end
    end
  endgenerate

  // Response shifter: bytes leave from the top of txBuf_r, one per handshake.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txData_r <= 8'h00;
      txValid_r <= 1'b0;
    end else if (txValid_r) begin
      if (txReady) begin
        txValid_r <= 1'b0;
      end
    end else if (state_r == ST_SEND && txLeft_r != 3'h0) begin
      txData_r <= txBuf_r[55:48];
      txValid_r <= 1'b1;
    end
  end

  // Main sequencer: decode, gather arguments, act, then answer.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      fePower_r <= 2'h0;
      drvEn_r <= 2'h0;
      feAnalogue_r <= 2'h0;
      feEnable_r <= 2'h0;
      binsSmall_r <= 2'h0;
      activePage_r <= 4'h0;
      readPage_r <= 4'h0;
      alarmCoarse_r <= 16'h0000;
      alarmFine_r <= 8'h00;
      timerClear_r <= 1'b0;
      calGenSel_r <= 2'h0;
      calTargets_r <= 4'h0;
      prescCode_r <= 4'h0;
      latchThr_r <= 8'h00;
      feCfgStart_r <= 1'b0;
      feCfgSel_r <= 2'h0;
      feCfgData_r <= 24'h000000;
      cmd_r <= 8'h00;
      arg_r <= 24'h000000;
      argLeft_r <= 2'h0;
      toCnt_r <= 32'h0;
      txBuf_r <= 56'h0;
      txLeft_r <= 3'h0;
      stream_r <= 1'b0;
      idx_r <= 8'h00;
      memWe_r <= 1'b0;
      memAddr_r <= 12'h000;
      memWData_r <= 24'h000000;
    end else begin
      feCfgStart_r <= 1'b0;
      timerClear_r <= 1'b0;
      memWe_r <= 1'b0;
      if (|latchDet_r) begin
        calTargets_r <= 4'h0; // see R20
      end
      unique case (state_r)
        ST_IDLE: begin
          if (rxValid) begin
            cmd_r <= rxData;
            toCnt_r <= 32'h0;
            txBuf_r <= {rxData, 48'h0};
            txLeft_r <= 3'h1;
            state_r <= ST_SEND;
            if (rxData[7:2] == `DFCD_OP_PWR) begin
              fePower_r <= pairBits(rxData); // see R2
            end else if (rxData[7:2] == `DFCD_OP_DRV) begin
              drvEn_r <= pairBits(rxData); // see R4
            end else if (rxData[7:2] == `DFCD_OP_TYPE) begin
              feAnalogue_r <= pairBits(rxData); // see R5
            end else if (rxData[7:2] == `DFCD_OP_EN) begin
              feEnable_r <= pairBits(rxData); // see R6
            end else if (rxData == `DFCD_OP_STAT) begin
              txBuf_r <= {pinIn_r[0], pinIn_r[1], pinIn_r[2], pinIn_r[3], pinIn_r[4],
                pinIn_r[6], pinIn_r[5], pinIn_r[7], rxData, 40'h0}; // see R9
              txLeft_r <= 3'h2;
            end else if (rxData == `DFCD_OP_TREAD) begin
              txBuf_r <= {timerCoarse, timerFine, rxData, 24'h0}; // see R15
              txLeft_r <= 3'h4;
            end else if (rxData == `DFCD_OP_STAMP) begin
              txBuf_r <= {stampA, stampB, rxData}; // see R16
              txLeft_r <= 3'h7;
            end else if (rxData[7:3] == `DFCD_OP_INIT) begin
              idx_r <= 8'h00;
              state_r <= ST_INIT;
            end else if (rxData[7:2] == `DFCD_OP_RD32) begin
              idx_r <= `DFCD_LAST_SMALL; // see R12
              txLeft_r <= 3'h0;
              state_r <= ST_CRD;
            end else if (rxData[7:2] == `DFCD_OP_RD256) begin
              idx_r <= `DFCD_LAST_FULL; // see R13
              txLeft_r <= 3'h0;
              state_r <= ST_CRD;
            end else if (rxData[7:2] == `DFCD_OP_CFG || rxData == `DFCD_OP_ALARM) begin
              argLeft_r <= 2'h3; // see R7 see R14
              state_r <= ST_ARG;
            end else if (rxData[7:2] == `DFCD_OP_MODE || rxData == `DFCD_OP_CAL
                || rxData[7:4] == `DFCD_OP_LATCH) begin
              argLeft_r <= 2'h1; // see R10 see R19 see R21
              state_r <= ST_ARG;
            end else begin
              txBuf_r <= {`DFCD_REPLY_UNK, 48'h0}; // see R17
            end
          end
        end
        ST_ARG: begin
          // The wait restarts at every byte; a stall answers and goes idle.
          if (rxValid) begin
            arg_r <= {arg_r[15:0], rxData};
            toCnt_r <= 32'h0;
            argLeft_r <= argLeft_r - 2'h1;
            if (argLeft_r == 2'h1) begin
              state_r <= ST_EXEC;
            end
          end else if (toCnt_r == 32'(ArgTimeoutCyc - 1)) begin
            txBuf_r <= {`DFCD_REPLY_TO, 48'h0}; // see R18 see R24
            txLeft_r <= 3'h1;
            state_r <= ST_SEND;
          end else begin
            toCnt_r <= toCnt_r + 32'h1; // see R24
          end
        end
        ST_EXEC: begin
          txBuf_r <= {cmd_r, 48'h0};
          txLeft_r <= 3'h1;
          state_r <= ST_SEND;
          if (cmd_r[7:2] == `DFCD_OP_CFG) begin
            feCfgSel_r <= fe; // see R7
            feCfgData_r <= arg_r;
            feCfgStart_r <= 1'b1;
            state_r <= ST_CFG;
          end else if (cmd_r == `DFCD_OP_ALARM) begin
            alarmCoarse_r <= arg_r[23:8]; // see R14
            alarmFine_r <= arg_r[7:0];
            timerClear_r <= 1'b1;
          end else if (cmd_r == `DFCD_OP_CAL) begin
            calGenSel_r <= arg_r[5:4]; // see R19
            calTargets_r <= (|latchDet_r) ? 4'h0 : arg_r[3:0]; // see R20
          end else if (cmd_r[7:4] == `DFCD_OP_LATCH) begin
            prescCode_r <= cmd_r[3:0]; // see R21
            latchThr_r <= arg_r[7:0];
          end else begin
            binsSmall_r <= pairBits(cmd_r); // see R10
            activePage_r <= {arg_r[3:2], arg_r[7:6]};
            readPage_r <= {arg_r[1:0], arg_r[5:4]};
          end
        end
        ST_CFG: begin
          // The front end's four status bytes lead, the echo follows.
          if (feCfgDone) begin
            txBuf_r <= {feCfgStatus, cmd_r, 16'h0}; // see R7
            txLeft_r <= 3'h5;
            state_r <= ST_SEND;
          end
        end
        ST_INIT: begin
          // One write per cycle into the addressed front end's read page.
          memWe_r <= 1'b1;
          memAddr_r <= {fe, (fe[1] ? readPage_r[3:2] : readPage_r[1:0]), idx_r};
          memWData_r <= fieldBit(cmd_r, 5) ? {12'h000, fe,
            (fe[1] ? readPage_r[3:2] : readPage_r[1:0]), idx_r} : 24'h000000; // see R11
          idx_r <= idx_r + 8'h01;
          if (idx_r == `DFCD_LAST_FULL) begin
            state_r <= ST_SEND; // see R11
          end
        end
        ST_CRD: begin
          memAddr_r <= {fe, (fe[1] ? readPage_r[3:2] : readPage_r[1:0]), idx_r};
          stream_r <= 1'b1;
          state_r <= ST_CLR;
          arg_r <= 24'h000000;
        end
        ST_CLR: begin
          // First visit waits for the registered read, second takes the data.
          if (arg_r[0]) begin
            txBuf_r <= {memRData, 32'h0}; // see R12 see R13
            txLeft_r <= 3'h3;
            memWe_r <= 1'b1;
            memWData_r <= 24'h000000;
            state_r <= ST_SEND;
          end
          arg_r <= 24'h000001;
        end
        ST_SEND: begin
          if (!txValid_r && txLeft_r != 3'h0) begin
            txBuf_r <= {txBuf_r[47:0], 8'h00};
            txLeft_r <= txLeft_r - 3'h1;
          end else if (!txValid_r) begin
            state_r <= ST_IDLE;
            if (stream_r) begin
              if (idx_r == 8'h00) begin
                stream_r <= 1'b0;
                txBuf_r <= {cmd_r, 48'h0}; // see R12 see R13
                txLeft_r <= 3'h1;
                state_r <= ST_SEND;
              end else begin
                idx_r <= idx_r - 8'h01;
                state_r <= ST_CRD;
              end
            end
          end
        end
      endcase
    end
  end

  dfcd_counter_ram #(
    .DW(24),
    .AW(12)
  ) uRam (
    .core_clk(core_clk),
    .we(memWe_r),
    .addr(memAddr_r),
    .wData(memWData_r),
    .rData(memRData)
  );
endmodule : dfcd_command_decoder

// file: dv/dfcd_fe_model.sv
// Front-end serial engine model answering configuration transfers.
`timescale 1ns/1ps
module dfcd_fe_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cfgStart,
  input wire logic [1:0] cfgSel,
  input wire logic [23:0] cfgData,
  input wire logic [7:0] delayCyc,
  output logic cfgDone,
  output logic [31:0] cfgStatus
);
  logic busy_r;
  logic [7:0] cnt_r;
  logic [3:0] hold_r;
  logic [31:0] word_r;
  // Status is only valid for a short hold after done; outside it the inverse shows.
  assign cfgStatus = (hold_r != 4'h0) ? word_r : ~word_r;
  // Serial transfer takes a programmable time before the status word returns.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      hold_r <= 4'h0;
      word_r <= 32'h0;
      cfgDone <= 1'b0;
    end else begin
      cfgDone <= 1'b0;
      if (cfgStart) begin
        busy_r <= 1'b1;
        cnt_r <= delayCyc;
        word_r <= {cfgData, 6'h00, cfgSel};
      end else if (busy_r && cnt_r == 8'h00) begin
        busy_r <= 1'b0;
        cfgDone <= 1'b1;
        hold_r <= 4'h8;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 8'h01;
      end else if (hold_r != 4'h0) begin
        hold_r <= hold_r - 4'h1;
      end
    end
  end
endmodule : dfcd_fe_model

// file: dv/dfcd_command_decoder_sva.sv
// Port-level checker for the command decoder.
`timescale 1ns/1ps
module dfcd_checker #(
  parameter int ArgTimeoutCyc = 50
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic [7:0] txData_r,
  input wire logic txValid_r,
  input wire logic txReady,
  input wire logic [1:0] fePower_r,
  input wire logic [1:0] feDriveOut_r,
  input wire logic [1:0] feResetOut_r,
  input wire logic [3:0] latchDet_r,
  input wire logic feCfgStart_r,
  input wire logic feCfgDone,
  input wire logic [31:0] feCfgStatus,
  input wire logic timerClear_r,
  input wire logic [3:0] calTargets_r
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [31:0] quietCnt_r;
  // Counts silent cycles so the late-argument reply can be placed in time.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      quietCnt_r <= 32'h0;
    end else if (rxValid || txValid_r) begin
      quietCnt_r <= 32'h0;
    end else begin
      quietCnt_r <= quietCnt_r + 32'h1;
    end
  end
  sequence s_echo(logic [7:0] b);
    txValid_r && txData_r == b;
  endsequence
  a_tx_hold: assert property (txValid_r && !txReady |=> txValid_r && $stable(txData_r))
    else $error("reply byte dropped or changed while stalled");
  a_tx_pace: assert property (txValid_r && txReady |=> !txValid_r)
    else $error("reply byte not released after acceptance");
  a_power_echo: assert property (
    rxValid && rxData[7:2] == 6'h20 |=> fePower_r == {$past(rxData[0]), $past(rxData[1])}
    ##1 s_echo($past(rxData, 2))) else $error("power command not applied or echoed");
  a_unknown_reply: assert property (
    rxValid && rxData == 8'h00 |-> ##2 s_echo(8'h03)) else $error("unknown reply wrong");
  a_pair_reset: assert property (
    (~fePower_r & ~$past(fePower_r) & ~feResetOut_r) == 2'b00)
    else $error("unpowered pair left out of reset");
  a_drive_gate: assert property (
    (feDriveOut_r & ~fePower_r & ~$past(fePower_r)) == 2'b00)
    else $error("unpowered pair driven");
  a_cfg_status: assert property (
    feCfgDone |-> ##[1:6] s_echo(feCfgStatus[31:24])) else $error("status byte wrong");
  a_cfg_quiet: assert property (
    feCfgStart_r |=> !feCfgStart_r && !txValid_r) else $error("start pulse too long");
  a_clear_echo: assert property (
    timerClear_r |=> !timerClear_r ##[0:2] s_echo(8'hd0)) else $error("alarm echo wrong");
  a_cal_drop: assert property (
    latchDet_r != 4'h0 && $past(latchDet_r) != 4'h0 |-> calTargets_r == 4'h0)
    else $error("calibration targets kept after latchup");
  a_timeout_gap: assert property (
    $rose(txValid_r) && txData_r == 8'h0f && quietCnt_r > 32'd16
    |-> quietCnt_r + 32'd8 >= ArgTimeoutCyc && quietCnt_r <= ArgTimeoutCyc + 8)
    else $error("argument time-out reply mistimed");
endmodule : dfcd_checker

// file: dv/tb_top.sv
// Self-checking bench for the command decoder.
`timescale 1ns/1ps
module tb_top;
  localparam int TO = 50;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] rxData = 8'h00;
  logic rxValid = 1'b0;
  logic txReady = 1'b0;
  logic [3:0] feCfgErrIn = 4'h0;
  logic [1:0] feLatchAnaIn = 2'h0;
  logic [1:0] feLatchDigIn = 2'h0;
  logic [15:0] timerCoarse = 16'h0000;
  logic [7:0] timerFine = 8'h00;
  logic [23:0] stampA = 24'h000000;
  logic [23:0] stampB = 24'h000000;
  logic [7:0] txData_r, alarmFine_r;
  logic txValid_r, feCfgStart_r, feCfgDone, timerClear_r;
  logic [1:0] fePower_r, feDriveOut_r, feAnalogue_r, feResetOut_r, feCfgSel_r;
  logic [1:0] binsSmall_r, calGenSel_r;
  logic [3:0] feErrFlag_r, latchDet_r, activePage_r, calTargets_r;
  logic [23:0] feCfgData_r;
  logic [31:0] feCfgStatus;
  logic [15:0] alarmCoarse_r;
  int errTotal = 0;
  int testsRun = 0;
  int cyc = 0;
  dfcd_command_decoder #(.ArgTimeoutCyc(TO)) dfcd_command_decoder_inst (
    .core_clk, .rst_n, .rxData, .rxValid, .txData_r, .txValid_r, .txReady,
    .feCfgErrIn, .feLatchAnaIn, .feLatchDigIn, .fePower_r, .feDriveOut_r,
    .feAnalogue_r, .feResetOut_r, .feErrFlag_r, .latchDet_r, .feCfgStart_r,
    .feCfgSel_r, .feCfgData_r, .feCfgDone, .feCfgStatus, .binsSmall_r, .activePage_r,
    .alarmCoarse_r, .alarmFine_r, .timerClear_r, .timerCoarse, .timerFine, .stampA,
    .stampB, .calGenSel_r, .calTargets_r);
  dfcd_fe_model dfcd_fe_model_inst (.core_clk, .rst_n, .cfgStart(feCfgStart_r),
    .cfgSel(feCfgSel_r), .cfgData(feCfgData_r), .delayCyc(8'd20), .cfgDone(feCfgDone),
    .cfgStatus(feCfgStatus));
  always #4 core_clk = ~core_clk;
  // The consumer stalls one cycle in three; the count also cuts a hang short.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    txReady <= (cyc % 3) != 1;
    if (cyc == 40000) begin
      errTotal++;
      final_report();
    end
  end
  task automatic final_report();
    $display("counts: %0d checks, %0d mismatches", testsRun, errTotal);
    if (errTotal == 0 && testsRun > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic put(input logic [7:0] b);
    @(posedge core_clk);
    rxData <= b;
    rxValid <= 1'b1;
    @(posedge core_clk);
    rxValid <= 1'b0;
  endtask : put
  task automatic get(input string nm, input logic [7:0] e);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!(txValid_r === 1'b1 && txReady === 1'b1) && n < 3000);
    chk(nm, e, txData_r);
  endtask : get
  task automatic xact(input string nm, input logic [7:0] s[$], input logic [7:0] e[$]);
    foreach (s[i]) put(s[i]);
    foreach (e[i]) get(nm, e[i]);
  endtask : xact
  task automatic t_frontend();
    xact("power", {8'h82}, {8'h82});
    chk("reset unenabled", 2'b11, feResetOut_r);
    xact("drive", {8'h87}, {8'h87});
    chk("drive", 2'b01, feDriveOut_r);
    xact("enable", {8'h8b}, {8'h8b});
    chk("pair reset", 2'b10, feResetOut_r);
    xact("type", {8'h8d}, {8'h8d});
    chk("analogue", 2'b10, feAnalogue_r);
    feCfgErrIn <= 4'b1001;
    feLatchDigIn <= 2'b10;
    repeat (8) @(posedge core_clk);
    xact("status", {8'h94}, {8'h91, 8'h94});
    chk("err flags", 4'b0001, feErrFlag_r);
    chk("masked latchup", 4'h0, latchDet_r);
    feCfgErrIn <= 4'h0;
    feLatchDigIn <= 2'h0;
    // Pair 0/1 is powered, driven and enabled before this transfer.
    xact("configure", {8'h91, 8'h12, 8'h34, 8'h56},
      {8'h12, 8'h34, 8'h56, 8'h01, 8'h91});
    chk("cfg data", 24'h123456, feCfgData_r);
    $display("test frontend done");
  endtask : t_frontend
  task automatic t_counters();
    logic [7:0] e[$];
    logic [7:0] f[$];
    xact("mode", {8'ha1, 8'h40}, {8'ha1});
    chk("bins", 2'b10, binsSmall_r);
    chk("active page", 4'b0001, activePage_r);
    xact("init", {8'had}, {8'had});
    for (int i = 31; i >= 0; i--) e = {e, 8'h00, 8'h04, 8'(i)};
    xact("read small", {8'hb1}, {e, 8'hb1});
    // Counters 31 to 0 were cleared by the small read, so all three bytes are zero.
    for (int i = 255; i >= 0; i--) begin
      f = {f, 8'h00, (i > 31) ? 8'h04 : 8'h00, (i > 31) ? 8'(i) : 8'h00};
    end
    xact("read full", {8'hb5}, {f, 8'hb5});
    // Fill with the pattern, then zero-fill, so the zero mode has something to erase.
    xact("init again", {8'had}, {8'had});
    xact("init zero", {8'ha9}, {8'ha9});
    e.delete();
    for (int i = 0; i < 96; i++) e = {e, 8'h00};
    xact("zeroed", {8'hb1}, {e, 8'hb1});
    $display("test counters done");
  endtask : t_counters
  task automatic t_timer();
    timerCoarse <= 16'hbeef;
    timerFine <= 8'h5a;
    stampA <= 24'h123456;
    stampB <= 24'hfedcba;
    xact("timer", {8'hd4}, {8'hbe, 8'hef, 8'h5a, 8'hd4});
    xact("stamp", {8'hd8}, {8'h12, 8'h34, 8'h56, 8'hfe, 8'hdc, 8'hba, 8'hd8});
    xact("alarm", {8'hd0, 8'h12, 8'h34, 8'h56}, {8'hd0});
    chk("alarm time", 24'h123456, {alarmCoarse_r, alarmFine_r});
    xact("unknown", {8'h00}, {8'h03});
    $display("test timer done");
  endtask : t_timer
  task automatic t_latch();
    int n;
    xact("cal", {8'he0, 8'h3f}, {8'he0});
    chk("cal setup", 6'h3f, {calGenSel_r, calTargets_r});
    xact("latch cfg", {8'hf0, 8'h02}, {8'hf0});
    feLatchAnaIn <= 2'b01;
    repeat (12) @(posedge core_clk);
    chk("early latchup", 4'h0, latchDet_r);
    n = 0;
    while (latchDet_r !== 4'b0001 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk("latchup", 4'b0001, latchDet_r);
    // The clear lands on the edge that first sees the detection, so wait one edge.
    @(posedge core_clk);
    chk("cal dropped", 4'h0, calTargets_r);
    feLatchAnaIn <= 2'b00;
    $display("test latch done");
  endtask : t_latch
  task automatic t_timeout();
    put(8'hd0);
    put(8'h12);
    repeat (TO - 8) @(posedge core_clk);
    chk("early timeout", 1'b0, txValid_r);
    get("timeout", 8'h0f);
    xact("idle again", {8'h00}, {8'h03});
    rst_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("power after reset", 2'b00, fePower_r);
    chk("reset after reset", 2'b11, feResetOut_r);
    $display("test timeout done");
  endtask : t_timeout
  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    chk("default power", 2'b00, fePower_r);
    chk("default type", 2'b00, feAnalogue_r);
    chk("default reset", 2'b11, feResetOut_r);
    t_frontend();
    t_counters();
    t_timer();
    t_latch();
    t_timeout();
    final_report();
  end
endmodule : tb_top
bind dfcd_command_decoder dfcd_checker #(.ArgTimeoutCyc(ArgTimeoutCyc)) dfcd_checker_inst (
  .core_clk, .rst_n, .rxData, .rxValid, .txData_r, .txValid_r, .txReady, .fePower_r,
  .feDriveOut_r, .feResetOut_r, .latchDet_r, .feCfgStart_r, .feCfgDone, .feCfgStatus,
  .timerClear_r, .calTargets_r);
